// File: rtl/mcml_latches.sv
`timescale 1ns/10ps
`default_nettype none
module mcml_latches #(
  parameter int STEP_NARROW_CYCLES = mcml_pkg::STEP_NARROW_CYC,
  parameter int STEP_WIDE_CYCLES = mcml_pkg::STEP_WIDE_CYC
)(
  // clock and power-on reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // serial configuration port, all idle high
  input wire logic cfg_sel_n_i,
  input wire logic cfg_sync_n_i,
  input wire logic cfg_clk_i,
  input wire logic cfg_data_i,
  // anti-fuse interface
  input wire logic [mcml_pkg::CFG_N-1:0] otp_fuse_i,
  output logic otp_sense_off_o,
  output logic otp_prog_o,
  output logic [5:0] otp_prog_addr_o,
  // stepper and channel path
  input wire logic step_pos_i,
  input wire logic step_neg_i,
  input wire logic tamper_on_i,
  input wire logic tamper_chan2_i,
  output logic stepper_out_positive_o,
  output logic stepper_out_negative_o,
  output logic cur_chan2_o,
  // decoded configuration
  output logic [7:0] secondary_current_gain_trim_o,
  output logic osc_plus_o,
  output logic osc_minus_o,
  output logic [15:0] knom_o,
  output logic [3:0] extra_current_gain_o,
  output logic [7:0] tamper_thr_o,
  output logic [23:0] step_width_o,
  // mode signals
  output logic charge_pump_drive_mode_o,
  output logic current_channel_select_o,
  output logic config_source_select_o,
  output logic permanent_write_enable_o
);

  // ==========================================================
  // state
  // ==========================================================
  // whole state of the block in one record
  typedef struct packed {
    logic [6:0] cmd; // bits shifted in so far
    logic [2:0] cnt; // bits received in this command
    logic scl_q; // previous serial clock level
    logic [mcml_pkg::CFG_N-1:0] shadow; // shadow latches
    logic pump; // charge pump mode
    logic current_channel_select; // channel select mode
    logic src; // source select mode
    logic we; // permanent write mode
    logic [mcml_pkg::PUMP_DIV_W-1:0] div; // pump drive divider
    logic prog; // anti-fuse program strobe
    logic [5:0] prog_addr; // anti-fuse program address
    logic step_p; // positive stepper output
    logic step_n; // negative stepper output
    logic chan2; // channel 2 in use
    logic [7:0] gain; // gain trim code
    logic osc_p; // oscillator plus correction
    logic osc_m; // oscillator minus correction
    logic [15:0] knom; // nominal voltage constant
    logic [3:0] extra_current_gain; // extra gain
    logic [7:0] thr; // tamper threshold
    logic [23:0] width; // stepper pulse width in cycles
  } mcml_state_t;

  mcml_state_t st_r;
  mcml_state_t st_nxt;

  // ==========================================================
  // helpers
  // ==========================================================
  // true when an address names one of the held configuration bits
  function automatic logic mcml_in_cfg(input logic [5:0] a);
    mcml_in_cfg = (a >= mcml_pkg::A_GAIN_LSB) && (a <= mcml_pkg::A_LVS);
  endfunction

  // nominal voltage constant for a two-bit code
  function automatic logic [15:0] mcml_knom(input logic [1:0] c);
    unique case (c)
      2'h0: mcml_knom = mcml_pkg::KNOM_0;
      2'h1: mcml_knom = mcml_pkg::KNOM_1;
      2'h2: mcml_knom = mcml_pkg::KNOM_2;
      2'h3: mcml_knom = mcml_pkg::KNOM_3;
    endcase
  endfunction

  // port is selected only with both select and sync low
  logic frame_on;
  // leading (falling) edge of the serial clock inside a frame
  logic lead_edge;
  // final bit of a command arrives on this edge
  logic exec;
  // bits in use: shadow or anti-fuse
  logic [mcml_pkg::CFG_N-1:0] cfg_eff;
  // index of the addressed shadow bit
  logic [5:0] cfg_idx;

  assign frame_on = !cfg_sel_n_i && !cfg_sync_n_i;
  assign lead_edge = frame_on && st_r.scl_q && !cfg_clk_i;
  assign exec = lead_edge && (st_r.cnt == mcml_pkg::LAST_BIT);
  assign cfg_eff = st_r.src ? st_r.shadow : otp_fuse_i;
  assign cfg_idx = st_r.cmd[5:0] - mcml_pkg::A_GAIN_LSB;

  // ==========================================================
  // next state
  // ==========================================================
  // serial shifting, bit writes and output decoding
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.scl_q = cfg_clk_i;
    st_nxt.prog = 1'b0;
    st_nxt.div = st_r.div + (mcml_pkg::PUMP_DIV_W)'(1);
    // shift the frame; an idle port restarts the command
    if (!frame_on)
    begin
      st_nxt.cnt = 3'h0;
    end
    else if (lead_edge)
    begin
      // data first, then address msb first, then don't care
      st_nxt.cmd = {st_r.cmd[5:0], cfg_data_i};
      st_nxt.cnt = st_r.cnt + 3'h1;
    end
    // the final bit's clock pulse latches the data bit
    if (exec)
    begin
      // shadow write; the top address is the field msb
      if (mcml_in_cfg(st_r.cmd[5:0]))
      begin
        st_nxt.shadow[cfg_idx[3:0]] = st_r.cmd[6];
        // with write enable the anti-fuse is also programmed
        if (st_r.we)
        begin
          st_nxt.prog = 1'b1;
          st_nxt.prog_addr = st_r.cmd[5:0];
        end
      end
      // mode bits by the same procedure
      else
      begin
        unique case (st_r.cmd[5:0])
          mcml_pkg::A_PUMP: st_nxt.pump = st_r.cmd[6];
          mcml_pkg::A_CURRENT_CHANNEL_SELECT: st_nxt.current_channel_select = st_r.cmd[6];
          mcml_pkg::A_SRC: st_nxt.src = st_r.cmd[6];
          mcml_pkg::A_WE: st_nxt.we = st_r.cmd[6];
          // other addresses change nothing
          default: st_nxt.pump = st_r.pump;
        endcase
      end
    end
    // stepper pins become complementary pump drive
    if (st_r.pump)
    begin
      st_nxt.step_p = st_r.div[mcml_pkg::PUMP_DIV_W-1];
      st_nxt.step_n = !st_r.div[mcml_pkg::PUMP_DIV_W-1];
    end
    else
    begin
      st_nxt.step_p = step_pos_i;
      st_nxt.step_n = step_neg_i;
    end
    // channel choice only counts while tamper is off
    st_nxt.chan2 = tamper_on_i ? tamper_chan2_i : st_r.current_channel_select;
    // gain trim code, 0 is -12.5 %, 255 is +12.5 %
    st_nxt.gain = cfg_eff[mcml_pkg::F_GAIN +: 8];
    // codes 0 and 3 leave the oscillator alone
    st_nxt.osc_p = (cfg_eff[mcml_pkg::F_OSC +: 2] == 2'h1);
    st_nxt.osc_m = (cfg_eff[mcml_pkg::F_OSC +: 2] == 2'h2);
    // nominal voltage constant
    st_nxt.knom = mcml_knom(cfg_eff[mcml_pkg::F_NOM +: 2]);
    // extra gain
    st_nxt.extra_current_gain = cfg_eff[mcml_pkg::F_EXTRA_CURRENT_GAIN] ? mcml_pkg::GAIN_ADD : 4'h0;
    // tamper threshold
    st_nxt.thr = cfg_eff[mcml_pkg::F_TAMPER_THRESHOLD_SELECT] ? mcml_pkg::THR_NARROW : mcml_pkg::THR_WIDE;
    // stepper pulse width
    st_nxt.width = cfg_eff[mcml_pkg::F_LVS] ? STEP_WIDE_CYCLES[23:0] : STEP_NARROW_CYCLES[23:0];
  end

  // ==========================================================
  // state register
  // ==========================================================
  // power-on reset clears every latch, modes included
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      st_r <= '0;
      st_r.scl_q <= 1'b1;
      st_r.knom <= mcml_pkg::KNOM_0;
      st_r.thr <= mcml_pkg::THR_WIDE;
      st_r.width <= STEP_NARROW_CYCLES[23:0];
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  // sense amplifiers cut off while shadow source is used
  assign otp_sense_off_o = st_r.src;
  assign otp_prog_o = st_r.prog;
  assign otp_prog_addr_o = st_r.prog_addr;
  assign stepper_out_positive_o = st_r.step_p;
  assign stepper_out_negative_o = st_r.step_n;
  assign cur_chan2_o = st_r.chan2;
  assign secondary_current_gain_trim_o = st_r.gain;
  assign osc_plus_o = st_r.osc_p;
  assign osc_minus_o = st_r.osc_m;
  assign knom_o = st_r.knom;
  assign extra_current_gain_o = st_r.extra_current_gain;
  assign tamper_thr_o = st_r.thr;
  assign step_width_o = st_r.width;
  assign charge_pump_drive_mode_o = st_r.pump;
  assign current_channel_select_o = st_r.current_channel_select;
  assign config_source_select_o = st_r.src;
  assign permanent_write_enable_o = st_r.we;

  // ==========================================================
  // assertions
  // ==========================================================
  default clocking mcml_cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // modes are clear on the first edge after reset
  a_mode_por_clear: assert property ($fell(sys_rst_i) |->
    !st_r.pump && !st_r.current_channel_select && !st_r.src && !st_r.we)
    else $error("mode signal not cleared by reset");

  // a pump-set command sets the mode next edge
  a_pump_write: assert property (exec && st_r.cmd == 7'h78 |=>
    charge_pump_drive_mode_o)
    else $error("pump mode not set by command");

  // a source-clear command clears the mode next edge
  a_src_write: assert property (exec && st_r.cmd == 7'h3D |=>
    !config_source_select_o)
    else $error("source mode not cleared by command");

  // pump mode drives the stepper pins in opposition
  a_pump_drive: assert property ($past(st_r.pump) && st_r.pump |=>
    stepper_out_positive_o != stepper_out_negative_o)
    else $error("pump drive not complementary");

  // channel follows mode select while tamper is off
  a_chan_select: assert property (!tamper_on_i |=>
    cur_chan2_o == $past(st_r.current_channel_select))
    else $error("channel select not applied");

  // sense amplifiers are cut off whenever source mode is set
  a_sense_off: assert property (config_source_select_o |->
    otp_sense_off_o)
    else $error("sense amplifier left connected");

  // a program strobe comes only from a held-bit write under we
  a_prog_cause: assert property (otp_prog_o |->
    $past(exec) && $past(st_r.we) && mcml_in_cfg(otp_prog_addr_o))
    else $error("stray anti-fuse program strobe");

  // an unknown address leaves every latch alone
  a_bad_addr: assert property (exec && st_r.cmd[5:0] == 6'h37 |=>
    $stable(st_r.shadow) && $stable({st_r.pump, st_r.current_channel_select, st_r.src, st_r.we}))
    else $error("unknown address changed a latch");

  // shadow bits do not change without a final command bit
  a_latch_only_exec: assert property (!exec |=> $stable(st_r.shadow))
    else $error("shadow bit changed outside a command");

  // extra gain is 8 two edges after a shadow write of bit 0x34
  a_extra_current_gain_value: assert property (st_r.src && exec && st_r.cmd == 7'h74 ##1 st_r.src
    |=> extra_current_gain_o == 4'h8)
    else $error("extra gain not applied");

  // stepper width follows the type bit
  a_step_width: assert property (cfg_eff[mcml_pkg::F_LVS] |=>
    step_width_o == STEP_WIDE_CYCLES[23:0])
    else $error("wide stepper width not selected");

  // oscillator corrections never both on
  a_osc_excl: assert property (!(osc_plus_o && osc_minus_o))
    else $error("both oscillator corrections active");

  // command counter restarts once the port goes idle
  a_frame_restart: assert property (!frame_on |=> st_r.cnt == 3'h0)
    else $error("command count kept across idle");

  // narrow tamper threshold follows the select bit
  a_thr_value: assert property (cfg_eff[mcml_pkg::F_TAMPER_THRESHOLD_SELECT] |=>
    tamper_thr_o == mcml_pkg::THR_NARROW)
    else $error("narrow tamper threshold not selected");

  // top nominal code gives the top constant
  a_knom_value: assert property (cfg_eff[mcml_pkg::F_NOM +: 2] == 2'h3 |=>
    knom_o == mcml_pkg::KNOM_3)
    else $error("nominal constant not decoded");

  // a write to the top gain address lands in the field msb
  a_gain_msb: assert property (exec && st_r.cmd == {1'b1, mcml_pkg::A_GAIN_LSB + 6'h7} |=>
    st_r.shadow[mcml_pkg::F_GAIN + 7])
    else $error("gain msb not written");

  // a channel-set command sets the mode next edge
  a_current_channel_select_write: assert property (exec && st_r.cmd == {1'b1, mcml_pkg::A_CURRENT_CHANNEL_SELECT} |=>
    current_channel_select_o)
    else $error("channel mode not set by command");

  // a write-enable-set command sets the mode next edge
  a_we_write: assert property (exec && st_r.cmd == {1'b1, mcml_pkg::A_WE} |=>
    permanent_write_enable_o)
    else $error("write enable mode not set by command");

  // main scenarios
  c_pump_on: cover property (exec ##1 charge_pump_drive_mode_o);
  c_prog_strobe: cover property (otp_prog_o);
  c_shadow_src: cover property (config_source_select_o ##1 cur_chan2_o);
  c_full_cmd: cover property (lead_edge ##[1:1000] exec);
  c_bad_addr: cover property (exec && st_r.cmd[5:0] == 6'h37);

endmodule
`default_nettype wire

// File: rtl/mcml_pkg.sv
// ==========================================================
// constants for the meter configuration and mode latches
// ==========================================================
package mcml_pkg;
  // clock rate of clk_i in MHz
  localparam int CLK_MHZ = 100;
  // serial command length in bits
  localparam logic [3:0] CMD_BITS = 4'h8;
  // index of the final bit of a command within the frame count
  localparam logic [2:0] LAST_BIT = 3'h7;
  // ==========================================================
  // bit addresses of the configuration bits held here
  // ==========================================================
  localparam logic [5:0] A_GAIN_LSB = 6'h28; // secondary_current_gain_trim
  localparam logic [5:0] A_OSC_LSB = 6'h30; // oscillator_trim
  localparam logic [5:0] A_NOM_LSB = 6'h32; // nominal_voltage_modifier
  localparam logic [5:0] A_EXTRA_CURRENT_GAIN = 6'h34; // extra_current_gain
  localparam logic [5:0] A_TAMPER_THRESHOLD_SELECT = 6'h35; // tamper_threshold_select
  localparam logic [5:0] A_LVS = 6'h36; // stepper_type_select
  // number of configuration bits held, 0x28 to 0x36
  localparam int CFG_N = 15;
  // field positions inside the held vector
  localparam int F_GAIN = 0;
  localparam int F_OSC = 8;
  localparam int F_NOM = 10;
  localparam int F_EXTRA_CURRENT_GAIN = 12;
  localparam int F_TAMPER_THRESHOLD_SELECT = 13;
  localparam int F_LVS = 14;
  // ==========================================================
  // bit addresses of the mode signals
  // ==========================================================
  localparam logic [5:0] A_PUMP = 6'h38; // charge_pump_drive_mode
  localparam logic [5:0] A_CURRENT_CHANNEL_SELECT = 6'h3C; // current_channel_select
  localparam logic [5:0] A_SRC = 6'h3D; // config_source_select
  localparam logic [5:0] A_WE = 6'h3E; // permanent_write_enable
  // ==========================================================
  // decoded values
  // ==========================================================
  // nominal voltage constants as unsigned 0.16 fixed point
  localparam logic [15:0] KNOM_0 = 16'h5C00; // 0.3594
  localparam logic [15:0] KNOM_1 = 16'h6400; // 0.3906
  localparam logic [15:0] KNOM_2 = 16'h6C00; // 0.4219
  localparam logic [15:0] KNOM_3 = 16'h7400; // 0.4531
  // extra current gain when enabled
  localparam logic [3:0] GAIN_ADD = 4'h8;
  // tamper thresholds as unsigned 0.8 fixed point
  localparam logic [7:0] THR_WIDE = 8'h20; // 12.5 %
  localparam logic [7:0] THR_NARROW = 8'h10; // 6.25 %
  // stepper pulse widths in ms
  localparam real STEP_NARROW_MS = 31.25;
  localparam real STEP_WIDE_MS = 156.25;
  localparam int STEP_NARROW_CYC = int'(STEP_NARROW_MS * 1000.0 * CLK_MHZ);
  localparam int STEP_WIDE_CYC = int'(STEP_WIDE_MS * 1000.0 * CLK_MHZ);
  // charge pump divider width
  localparam int PUMP_DIV_W = 4;
endpackage

// File: tb/mcml_host.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// host model driving the serial config port
// ==========================================
module mcml_host (
  // clock
  input wire logic clk_i,
  // serial configuration port
  output logic cfg_sel_n_o,
  output logic cfg_sync_n_o,
  output logic cfg_clk_o,
  output logic cfg_data_o
);
  // clk cycles each serial level is held, 1 is prompt
  int hold = 1;
  // idle: pull-ups hold every line high
  initial
  begin
    cfg_sel_n_o = 1'b1;
    cfg_sync_n_o = 1'b1;
    cfg_clk_o = 1'b1;
    cfg_data_o = 1'b1;
  end
  // wait n falling clk edges
  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // open a frame with the serial clock idle high
  task automatic open_frame();
    wt(1);
    cfg_sel_n_o = 1'b0;
    cfg_sync_n_o = 1'b0;
    wt(hold);
  endtask
  // send the top nbits of a command, msb first
  task automatic send(input logic [7:0] cmd, input int nbits);
    for (int i = 7; i > 7 - nbits; i--)
    begin
      cfg_data_o = cmd[i]; // data moves while the clock is high
      wt(hold);
      cfg_clk_o = 1'b0; // leading edge takes the bit
      wt(hold);
      cfg_clk_o = 1'b1;
      wt(hold);
    end
  endtask
  // end the frame, lines fall back to the pull-up level
  task automatic close_frame();
    cfg_sel_n_o = 1'b1;
    cfg_sync_n_o = 1'b1;
    cfg_data_o = 1'b1;
    wt(1);
  endtask
endmodule
`default_nettype wire

// File: tb/tb_mcml_latches.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// testbench for the config and mode latches
// ==========================================
module tb_mcml_latches;
  // short stepper widths keep the run small
  localparam int NARROW = 20;
  localparam int WIDE = 100;
  // stimulus and counters
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [14:0] fuse = 15'h59A5;
  logic st_pos = 1'b0, st_neg = 1'b0, tmp_on = 1'b0, tmp_ch2 = 1'b0;
  logic sel_n, sync_n, scl, sda;
  int error_cnt = 0, n_checks = 0, prog_cnt = 0;
  logic [5:0] prog_addr = 6'h00;
  // design outputs
  logic sense_off, prog, pos_o, neg_o, chan2, osc_p, osc_m, pump, current_channel_select, src, we;
  logic [5:0] paddr;
  logic [7:0] gain, thr;
  logic [15:0] knom;
  logic [3:0] extra;
  logic [23:0] stepw;
  // 100 MHz clock
  always #5 clk_i = ~clk_i;
  // count anti-fuse program strobes
  always @(posedge clk_i)
    if (prog === 1'b1)
    begin
      prog_cnt++;
      prog_addr = paddr;
    end
  mcml_host i_host (.clk_i(clk_i), .cfg_sel_n_o(sel_n), .cfg_sync_n_o(sync_n),
    .cfg_clk_o(scl), .cfg_data_o(sda));
  mcml_latches #(.STEP_NARROW_CYCLES(NARROW), .STEP_WIDE_CYCLES(WIDE)) i_dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .cfg_sel_n_i(sel_n), .cfg_sync_n_i(sync_n),
    .cfg_clk_i(scl), .cfg_data_i(sda), .otp_fuse_i(fuse), .otp_sense_off_o(sense_off),
    .otp_prog_o(prog), .otp_prog_addr_o(paddr), .step_pos_i(st_pos), .step_neg_i(st_neg),
    .tamper_on_i(tmp_on), .tamper_chan2_i(tmp_ch2), .stepper_out_positive_o(pos_o),
    .stepper_out_negative_o(neg_o), .cur_chan2_o(chan2),
    .secondary_current_gain_trim_o(gain), .osc_plus_o(osc_p), .osc_minus_o(osc_m),
    .knom_o(knom), .extra_current_gain_o(extra), .tamper_thr_o(thr), .step_width_o(stepw),
    .charge_pump_drive_mode_o(pump), .current_channel_select_o(current_channel_select),
    .config_source_select_o(src), .permanent_write_enable_o(we));
  // ==========================================
  // helpers
  // ==========================================
  // compare and count
  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one bit write in its own frame, then let outputs settle
  task automatic wr(input logic [5:0] a, input logic v);
    i_host.open_frame();
    i_host.send({v, a, 1'b0}, 8);
    i_host.close_frame();
    repeat (3) @(negedge clk_i);
  endtask
  // decoded configuration against the field values
  task automatic chk_cfg(input logic [7:0] g, input logic [1:0] o, input logic [1:0] n,
    input logic a, input logic c, input logic l);
    logic [15:0] kn [4];
    kn = '{mcml_pkg::KNOM_0, mcml_pkg::KNOM_1, mcml_pkg::KNOM_2, mcml_pkg::KNOM_3};
    chk("gain", 24'(g), 24'(gain));
    chk("osc", 24'({o == 2'h1, o == 2'h2}), 24'({osc_p, osc_m}));
    chk("knom", 24'(kn[n]), 24'(knom));
    chk("extra", a ? 24'h8 : 24'h0, 24'(extra));
    chk("thr", c ? 24'h10 : 24'h20, 24'(thr));
    chk("stepw", l ? 24'(WIDE) : 24'(NARROW), stepw);
  endtask
  // verdict and end of run
  task automatic report_and_stop();
    if (error_cnt == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // hang guard
  initial
  begin
    #400000;
    error_cnt++;
    report_and_stop();
  end
  // ==========================================
  // scenarios
  // ==========================================
  initial
  begin
    int same;
    int tog;
    logic [6:0] bad [6];
    bad = '{7'h79, 7'h7B, 7'h7F, 7'h77, 7'h00, 7'h27};
    repeat (20) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    chk("modes", 24'h0, 24'({pump, current_channel_select, src, we}));
    chk_cfg(8'hA5, 2'h1, 2'h2, 1'b1, 1'b0, 1'b1);
    wr(mcml_pkg::A_SRC, 1'b1);
    chk("sense_off", 24'h1, 24'(sense_off));
    chk_cfg(8'h00, 2'h0, 2'h0, 1'b0, 1'b0, 1'b0);
    // gain 0x81 bit by bit, msb at the highest address
    for (int b = 0; b < 8; b++)
      wr(mcml_pkg::A_GAIN_LSB + 6'(b), b == 0 || b == 7);
    chk_cfg(8'h81, 2'h0, 2'h0, 1'b0, 1'b0, 1'b0);
    // every code of every field except the gain
    for (int k = 0; k < 4; k++)
    begin
      wr(mcml_pkg::A_OSC_LSB, k[0]);
      wr(mcml_pkg::A_OSC_LSB + 6'h1, k[1]);
      wr(mcml_pkg::A_NOM_LSB, k[0]);
      wr(mcml_pkg::A_NOM_LSB + 6'h1, k[1]);
      wr(mcml_pkg::A_EXTRA_CURRENT_GAIN, k[0]);
      wr(mcml_pkg::A_TAMPER_THRESHOLD_SELECT, k[1]);
      wr(mcml_pkg::A_LVS, k[0]);
      chk_cfg(8'h81, k[1:0], k[1:0], k[0], k[1], k[0]);
    end
    // unmapped addresses change nothing
    for (int j = 0; j < 6; j++)
      wr(bad[j][5:0], bad[j][6]);
    chk_cfg(8'h81, 2'h3, 2'h3, 1'b1, 1'b1, 1'b1);
    chk("modes", 24'h2, 24'({pump, current_channel_select, src, we}));
    // partial command dropped at frame end
    i_host.open_frame();
    i_host.send({1'b0, mcml_pkg::A_EXTRA_CURRENT_GAIN, 1'b0}, 4);
    i_host.close_frame();
    wr(mcml_pkg::A_TAMPER_THRESHOLD_SELECT, 1'b0);
    chk_cfg(8'h81, 2'h3, 2'h3, 1'b1, 1'b0, 1'b1);
    // two commands back to back in one slow frame
    i_host.hold = 3;
    i_host.open_frame();
    i_host.send({1'b1, mcml_pkg::A_PUMP, 1'b1}, 8);
    i_host.send({1'b1, mcml_pkg::A_CURRENT_CHANNEL_SELECT, 1'b0}, 8);
    i_host.close_frame();
    i_host.hold = 1;
    repeat (3) @(negedge clk_i);
    chk("modes_on", 24'hE, 24'({pump, current_channel_select, src, we}));
    same = 0;
    tog = 0;
    for (int c = 0; c < 32; c++)
    begin
      @(negedge clk_i);
      same += (pos_o === neg_o);
      if (c > 0 && pos_o !== st_pos)
        tog++;
    end
    chk("pump_same", 24'h0, 24'(same));
    chk("pump_run", 24'h1, 24'(tog > 4 && tog < 28));
    chk("chan2", 24'h1, 24'(chan2));
    tmp_on = 1'b1;
    repeat (2) @(negedge clk_i);
    chk("chan2_tamper", 24'h0, 24'(chan2));
    tmp_on = 1'b0;
    wr(mcml_pkg::A_CURRENT_CHANNEL_SELECT, 1'b0);
    chk("chan1", 24'h0, 24'(chan2));
    wr(mcml_pkg::A_PUMP, 1'b0);
    st_pos = 1'b1;
    repeat (2) @(negedge clk_i);
    chk("step_pins", 24'h2, 24'({pos_o, neg_o}));
    // permanent write, source mode stays set meanwhile
    wr(mcml_pkg::A_WE, 1'b1);
    chk("src_we_on", 24'h3, 24'({src, we}));
    prog_cnt = 0;
    wr(mcml_pkg::A_GAIN_LSB, 1'b0);
    chk("prog_cnt", 24'h1, 24'(prog_cnt));
    chk("prog_addr", 24'h28, 24'(prog_addr));
    wr(mcml_pkg::A_WE, 1'b0);
    wr(mcml_pkg::A_GAIN_LSB, 1'b1);
    chk("prog_none", 24'h1, 24'(prog_cnt));
    chk("gain_back", 24'h81, 24'(gain));
    // second power-on reset
    sys_rst_i = 1'b1;
    repeat (3) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    chk("modes_rst", 24'h0, 24'({pump, current_channel_select, src, we, sense_off}));
    chk_cfg(8'hA5, 2'h1, 2'h2, 1'b1, 1'b0, 1'b1);
    report_and_stop();
  end
endmodule
`default_nettype wire
